// ### tpp_consts.svh
// tpp_consts.svh - register offsets, field positions and reset values
// assumes: included by tpp_pkg and by every design file of the pwm pair
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH

// ==========================================================================
// register offsets (byte addresses, one word each)
`define TPP_ADDR_W       8
`define TPP_CTRL_OFS     8'h00
`define TPP_STAT_OFS     8'h04
`define TPP_MRLD_OFS     8'h08
`define TPP_SRLD_OFS     8'h0c
`define TPP_MCNT_OFS     8'h10
`define TPP_SCNT_OFS     8'h14
`define TPP_OUTC_OFS     8'h18
`define TPP_PSC_OFS      8'h1c

// ==========================================================================
// field positions
`define TPP_CTRL_MSTART  0
`define TPP_CTRL_SSTART  1
`define TPP_CTRL_MHALT   2
`define TPP_CTRL_SHALT   3
`define TPP_STAT_MEN     0
`define TPP_STAT_SEN     1
`define TPP_OUTC_TOUT    0
`define TPP_OUTC_TOE     1
`define TPP_OUTC_LVL     2
`define TPP_OUTC_UCE     3
`define TPP_OUTC_PHOLD   4
`define TPP_OUTC_PLVL    5

// ==========================================================================
// widths and reset values
`define TPP_DATA_W       32
`define TPP_CNT_W        16
`define TPP_PSC_W        8
`define TPP_CNT_RST      16'h0000
`define TPP_PSC_RST      8'h00
`define TPP_DATA_RST     32'h0000_0000

`endif

// ### tpp_pkg.sv
// tpp_pkg.sv - state types of the pwm pair
// assumes: tpp_consts.svh sits in the same folder
`include "tpp_consts.svh"

package tpp_pkg;

	// ==================================================================
	// master channel sequence
	typedef enum logic [1:0] {
		MS_STOP = 2'b00,
		MS_PEND = 2'b01,
		MS_RUN  = 2'b10
	} tpp_mstate_type;

	// ==================================================================
	// slave channel sequence
	typedef enum logic [1:0] {
		SL_STOP = 2'b00,
		SL_WAIT = 2'b01,
		SL_RUN  = 2'b10
	} tpp_sstate_type;

endpackage

// ### tpp_chan.sv
// tpp_chan.sv - one down counter with load, decrement and clear
// assumes: single clock, reset already synchronised by the caller
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"

module tpp_chan
	import tpp_pkg::*;
#(
	parameter int unsigned CW = `TPP_CNT_W
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// control
	input  wire logic          clr_i,
	input  wire logic          load_i,
	input  wire logic          dec_i,
	input  wire logic [CW-1:0] load_val_i,
	// state
	output logic      [CW-1:0] cnt_o,
	output logic               zero_o
);

	logic [CW-1:0] cnt_ff;

	// load wins over decrement; a counter at zero holds rather than wraps
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else if (clr_i) begin
			cnt_ff <= '0;
		end else if (load_i) begin
			cnt_ff <= load_val_i;
		end else if (dec_i && (cnt_ff != '0)) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	assign cnt_o  = cnt_ff;
	assign zero_o = (cnt_ff == '0);

endmodule
`default_nettype wire

// ### tpp_top.sv
// tpp_top.sv - master/slave timer pair forming one pwm output
// assumes: one 250 MHz clock; registers reached over a plain strobe port
// with read data one cycle after the read strobe
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"

module tpp_top
	import tpp_pkg::*;
#(
	parameter int unsigned UNIT_NUM  = 0,
	parameter int unsigned MASTER_CH = 0,
	parameter int unsigned CW        = `TPP_CNT_W,
	parameter int unsigned PW        = `TPP_PSC_W
) (
	// clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_n_i,
	// register port
	input  wire logic [`TPP_ADDR_W-1:0]  reg_addr_i,
	input  wire logic [`TPP_DATA_W-1:0]  reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [`TPP_DATA_W-1:0]  reg_rdata_o,
	// slave output pin
	output logic                         pwm_pin_o,
	output logic                         pwm_pin_oe_o,
	// master end event
	output logic                         chan_end_o
);

	// ==================================================================
	// reset release
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic rst_n;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign rst_n = rst_sync_ff;

	// ==================================================================
	// address decode
	function automatic logic hit(
		input logic [`TPP_ADDR_W-1:0] addr,
		input logic [`TPP_ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction

	logic wr_ctrl;
	logic wr_mrld;
	logic wr_srld;
	logic wr_outc;
	logic wr_psc;
	logic start_m;
	logic start_s;
	logic halt_m;
	logic halt_s;

	assign wr_ctrl = reg_wr_i && hit(reg_addr_i, `TPP_CTRL_OFS);
	assign wr_mrld = reg_wr_i && hit(reg_addr_i, `TPP_MRLD_OFS);
	assign wr_srld = reg_wr_i && hit(reg_addr_i, `TPP_SRLD_OFS);
	assign wr_outc = reg_wr_i && hit(reg_addr_i, `TPP_OUTC_OFS);
	assign wr_psc  = reg_wr_i && hit(reg_addr_i, `TPP_PSC_OFS);

	// triggers are only decoded from the write, never stored
	assign start_m = wr_ctrl && reg_wdata_i[`TPP_CTRL_MSTART];
	assign start_s = wr_ctrl && reg_wdata_i[`TPP_CTRL_SSTART];
	assign halt_m  = wr_ctrl && reg_wdata_i[`TPP_CTRL_MHALT];
	assign halt_s  = wr_ctrl && reg_wdata_i[`TPP_CTRL_SHALT];

	// ==================================================================
	// output control and unit clock enable
	logic tout_ff;
	logic toe_ff;
	logic lvl_ff;
	logic uce_ff;
	logic phold_ff;
	logic plvl_ff;
	logic clr;
	logic act_lvl;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			toe_ff   <= 1'b0;
			lvl_ff   <= 1'b0;
			uce_ff   <= 1'b0;
			phold_ff <= 1'b0;
			plvl_ff  <= 1'b0;
		end else if (wr_outc) begin
			toe_ff   <= reg_wdata_i[`TPP_OUTC_TOE];
			lvl_ff   <= reg_wdata_i[`TPP_OUTC_LVL];
			uce_ff   <= reg_wdata_i[`TPP_OUTC_UCE];
			phold_ff <= reg_wdata_i[`TPP_OUTC_PHOLD];
			plvl_ff  <= reg_wdata_i[`TPP_OUTC_PLVL];
		end
	end

	// unit clock off behaves as power-off of the channel logic
	assign clr     = !uce_ff;
	// level bit set means the active level is low
	assign act_lvl = !lvl_ff;

	// ==================================================================
	// reload values and count clock divider
	logic [CW-1:0] m_reload_ff;
	logic [CW-1:0] s_reload_ff;
	logic [PW-1:0] psc_ff;
	logic [PW-1:0] div_ff;
	logic          tick;

	// no shadow register: a reload written mid-period is taken at the next end event,
	// which is why software waits for the master end event
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			m_reload_ff <= `TPP_CNT_RST;
			s_reload_ff <= `TPP_CNT_RST;
		end else if (clr) begin
			m_reload_ff <= `TPP_CNT_RST;
			s_reload_ff <= `TPP_CNT_RST;
		end else begin
			if (wr_mrld) begin
				m_reload_ff <= reg_wdata_i[CW-1:0];
			end
			if (wr_srld) begin
				s_reload_ff <= reg_wdata_i[CW-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			psc_ff <= `TPP_PSC_RST;
		end else if (wr_psc) begin
			psc_ff <= reg_wdata_i[PW-1:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= '0;
		end else if (clr || (div_ff >= psc_ff)) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	// one count clock is a one-cycle enable every psc+1 system clocks;
	// a prescale lowered mid-count must not let the divider run to wrap
	assign tick = uce_ff && (div_ff >= psc_ff);

	// ==================================================================
	// master channel
	tpp_mstate_type mstate_ff;
	logic [CW-1:0]  m_cnt;
	logic           m_zero;
	logic           m_irq;
	logic           m_dec;
	logic           m_en;

	// halt wins over a start written in the same word
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mstate_ff <= MS_STOP;
		end else if (clr || halt_m) begin
			mstate_ff <= MS_STOP;
		end else begin
			case (mstate_ff)
			MS_STOP: begin
				if (start_m) begin
					mstate_ff <= MS_PEND;
				end
			end
			MS_PEND: begin
				if (tick) begin
					mstate_ff <= MS_RUN;
				end
			end
			MS_RUN: begin
				if (start_m) begin
					mstate_ff <= MS_PEND;
				end
			end
			default: begin
				mstate_ff <= MS_STOP;
			end
			endcase
		end
	end

	assign m_en  = (mstate_ff != MS_STOP);
	// end event at the first count clock and at every wrap through zero
	assign m_irq = tick && ((mstate_ff == MS_PEND) ||
		((mstate_ff == MS_RUN) && m_zero));
	assign m_dec = tick && (mstate_ff == MS_RUN) && !m_zero;

	tpp_chan #(
		.CW         (CW)
	) u_master (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n),
		.clr_i      (clr),
		.load_i     (m_irq),
		.dec_i      (m_dec),
		.load_val_i (m_reload_ff),
		.cnt_o      (m_cnt),
		.zero_o     (m_zero)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			chan_end_o <= 1'b0;
		end else begin
			chan_end_o <= m_irq;
		end
	end

	// ==================================================================
	// slave channel
	tpp_sstate_type sstate_ff;
	logic [CW-1:0]  s_cnt;
	logic           s_zero;
	logic           s_en;
	logic           s_load;
	logic           s_step;
	logic           hw_set;
	logic           hw_clr;

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sstate_ff <= SL_STOP;
		end else if (clr || halt_s) begin
			sstate_ff <= SL_STOP;
		end else begin
			case (sstate_ff)
			SL_STOP: begin
				if (start_s) begin
					sstate_ff <= SL_WAIT;
				end
			end
			SL_WAIT: begin
				if (m_irq) begin
					sstate_ff <= SL_RUN;
				end
			end
			SL_RUN: begin
				if (!m_irq && tick && s_zero) begin
					sstate_ff <= SL_WAIT;
				end
			end
			default: begin
				sstate_ff <= SL_STOP;
			end
			endcase
		end
	end

	assign s_en   = (sstate_ff != SL_STOP);
	assign s_load = m_irq && s_en;
	// a fresh end event restarts the slave even if it is still running
	assign s_step = tick && (sstate_ff == SL_RUN) && !m_irq;
	assign hw_set = s_step && !s_zero;
	assign hw_clr = s_step && s_zero;

	tpp_chan #(
		.CW         (CW)
	) u_slave (
		.clk_i      (sys_clk_i),
		.rst_n_i    (rst_n),
		.clr_i      (clr),
		.load_i     (s_load),
		.dec_i      (s_step),
		.load_val_i (s_reload_ff),
		.cnt_o      (s_cnt),
		.zero_o     (s_zero)
	);

	// ==================================================================
	// timer output bit: hardware updates only while output is enabled,
	// and a hardware update wins over a software write in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tout_ff <= 1'b0;
		end else if (clr) begin
			tout_ff <= 1'b0;
		end else if (toe_ff && hw_set) begin
			tout_ff <= act_lvl;
		end else if (toe_ff && hw_clr) begin
			tout_ff <= !act_lvl;
		end else if (wr_outc) begin
			tout_ff <= reg_wdata_i[`TPP_OUTC_TOUT];
		end
	end

	// ==================================================================
	// pin: timer output while the unit runs, port function otherwise
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwm_pin_o    <= 1'b0;
			pwm_pin_oe_o <= 1'b0;
		end else if (uce_ff) begin
			pwm_pin_o    <= tout_ff;
			pwm_pin_oe_o <= 1'b1;
		end else begin
			pwm_pin_o    <= plvl_ff;
			pwm_pin_oe_o <= phold_ff;
		end
	end

	// ==================================================================
	// register read
	logic [`TPP_DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = `TPP_DATA_RST;
		case (reg_addr_i)
		`TPP_STAT_OFS: begin
			rd_mux[`TPP_STAT_MEN] = m_en;
			rd_mux[`TPP_STAT_SEN] = s_en;
		end
		`TPP_MRLD_OFS: rd_mux[CW-1:0] = m_reload_ff;
		`TPP_SRLD_OFS: rd_mux[CW-1:0] = s_reload_ff;
		`TPP_MCNT_OFS: rd_mux[CW-1:0] = m_cnt;
		`TPP_SCNT_OFS: rd_mux[CW-1:0] = s_cnt;
		`TPP_OUTC_OFS: begin
			rd_mux[`TPP_OUTC_TOUT]  = tout_ff;
			rd_mux[`TPP_OUTC_TOE]   = toe_ff;
			rd_mux[`TPP_OUTC_LVL]   = lvl_ff;
			rd_mux[`TPP_OUTC_UCE]   = uce_ff;
			rd_mux[`TPP_OUTC_PHOLD] = phold_ff;
			rd_mux[`TPP_OUTC_PLVL]  = plvl_ff;
		end
		`TPP_PSC_OFS: rd_mux[PW-1:0] = psc_ff;
		default: rd_mux = `TPP_DATA_RST; // control word reads zero
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= `TPP_DATA_RST;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end else begin
			reg_rdata_o <= `TPP_DATA_RST;
		end
	end

	// ==================================================================
	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence both_start_s;
		start_m && start_s && !halt_m && !halt_s && uce_ff;
	endsequence

	sequence master_wrap_s;
		tick && (mstate_ff == MS_RUN) && m_zero && !start_m && !halt_m
			&& uce_ff && !clr;
	endsequence

	sequence slave_kick_s;
		m_irq && (sstate_ff == SL_WAIT) && toe_ff && (psc_ff == '0)
			&& (s_reload_ff > 1) && !wr_outc && !wr_ctrl;
	endsequence

	legal_place_a: assert property (
		(UNIT_NUM <= 1) && (MASTER_CH % 2 == 0) && (MASTER_CH <= 6))
		else $error("master channel or unit number out of range");

	ctrl_reads_zero_a: assert property (
		reg_rd_i && hit(reg_addr_i, `TPP_CTRL_OFS) |=> reg_rdata_o == '0)
		else $error("control word did not read back as zero");

	start_enable_a: assert property (
		both_start_s |=> (mstate_ff == MS_PEND) && m_en && s_en)
		else $error("start did not set both enable bits");

	first_event_a: assert property (
		$rose(mstate_ff == MS_PEND) |-> ##[0:257]
			(m_irq || (mstate_ff == MS_STOP)))
		else $error("no end event after master start");

	master_dec_a: assert property (
		m_dec && !clr && !halt_m && !start_m |=> m_cnt == $past(m_cnt) - 1'b1)
		else $error("master counter did not step down");

	master_wrap_a: assert property (
		master_wrap_s |-> m_irq ##1 (m_cnt == $past(m_reload_ff))
			&& chan_end_o)
		else $error("master did not reload with end event at zero");

	slave_load_a: assert property (
		m_irq && s_en && !halt_s && !clr |=> (s_cnt == $past(s_reload_ff))
			&& (sstate_ff == SL_RUN))
		else $error("slave not reloaded on master end event");

	slave_active_a: assert property (
		slave_kick_s |-> ##2 (tout_ff == act_lvl) || !s_en || clr)
		else $error("slave output not active one count clock later");

	slave_stop_a: assert property (
		hw_clr && toe_ff && !clr && !halt_s |=> (tout_ff != act_lvl)
			&& (sstate_ff == SL_WAIT))
		else $error("slave did not go inactive at zero");

	halt_hold_a: assert property (
		halt_m && halt_s && uce_ff |=> !m_en && !s_en
			##1 $stable(m_cnt) && $stable(s_cnt))
		else $error("halt did not stop both channels");

	halt_keep_out_a: assert property (
		!s_en && uce_ff && !wr_outc |=> $stable(tout_ff))
		else $error("timer output changed while halted");

	pin_follow_a: assert property (
		uce_ff |=> pwm_pin_oe_o && (pwm_pin_o == $past(tout_ff)))
		else $error("pin does not follow timer output");

	port_hold_a: assert property (
		!uce_ff && phold_ff |=> pwm_pin_oe_o && (pwm_pin_o == $past(plvl_ff)))
		else $error("pin not held at port level");

	pin_float_a: assert property (
		!uce_ff && !phold_ff |=> !pwm_pin_oe_o)
		else $error("pin driven with unit off and no port hold");

	power_off_a: assert property (
		!uce_ff && !wr_outc |=> !tout_ff && (m_cnt == '0) && (s_cnt == '0)
			&& !m_en && !s_en)
		else $error("channel state not cleared with unit off");

endmodule
`default_nettype wire

// ### tb_timer_pair_pwm.sv
// tb_timer_pair_pwm.sv - self-checking bench for the pwm timer pair
// assumes: tpp_top and tpp_consts.svh in one folder, one 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"

module tb_timer_pair_pwm;

	// ==================================================================
	// signals and settings
	logic                   sys_clk_i;
	logic                   reset_n_i;
	logic [`TPP_ADDR_W-1:0] reg_addr_i;
	logic [`TPP_DATA_W-1:0] reg_wdata_i;
	logic                   reg_wr_i;
	logic                   reg_rd_i;
	logic [`TPP_DATA_W-1:0] reg_rdata_o;
	logic                   pwm_pin_o;
	logic                   pwm_pin_oe_o;
	logic                   chan_end_o;
	logic [`TPP_DATA_W-1:0] rv;
	logic [`TPP_DATA_W-1:0] rv2;
	logic                   pv;
	int                     errors = 0;
	int                     num_checks = 0;
	int                     cyc = 0;
	int                     per;
	int                     hi;
	int                     first;
	int                     tab_r [3] = '{6, 9, 4};
	int                     tab_s [3] = '{3, 1, 2};
	int                     tab_p [3] = '{1, 2, 0};
	localparam int          CEIL  = 20000;
	localparam logic [31:0] TOUT  = 32'h1 << `TPP_OUTC_TOUT;
	localparam logic [31:0] TOE   = 32'h1 << `TPP_OUTC_TOE;
	localparam logic [31:0] UCE   = 32'h1 << `TPP_OUTC_UCE;
	localparam logic [31:0] LVL   = 32'h1 << `TPP_OUTC_LVL;
	localparam logic [31:0] PHOLD = 32'h1 << `TPP_OUTC_PHOLD;
	localparam logic [31:0] PLVL  = 32'h1 << `TPP_OUTC_PLVL;
	localparam logic [31:0] START = (32'h1 << `TPP_CTRL_MSTART) |
		(32'h1 << `TPP_CTRL_SSTART);
	localparam logic [31:0] HALT  = (32'h1 << `TPP_CTRL_MHALT) |
		(32'h1 << `TPP_CTRL_SHALT);

	// a non-default unit and the highest master channel
	tpp_top #(
		.UNIT_NUM  (1),
		.MASTER_CH (6)
	) i_tpp_top (
		.sys_clk_i    (sys_clk_i),
		.reset_n_i    (reset_n_i),
		.reg_addr_i   (reg_addr_i),
		.reg_wdata_i  (reg_wdata_i),
		.reg_wr_i     (reg_wr_i),
		.reg_rd_i     (reg_rd_i),
		.reg_rdata_o  (reg_rdata_o),
		.pwm_pin_o    (pwm_pin_o),
		.pwm_pin_oe_o (pwm_pin_oe_o),
		.chan_end_o   (chan_end_o)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// ==================================================================
	// tasks
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cyc = cyc + 1;
		if (cyc == CEIL) begin
			errors = errors + 1;
			conclude();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic wait_end();
		for (int i = 0; i < 1000; i++) begin
			@(posedge sys_clk_i);
			#1;
			if (chan_end_o === 1'b1) break;
		end
		chk_pin(chan_end_o, 1'b1);
	endtask

	// one period from end pulse to end pulse, with pin high count
	task automatic measure();
		per = 0;
		hi = 0;
		first = 0;
		wait_end();
		do begin
			@(posedge sys_clk_i);
			#1;
			per++;
			if (pwm_pin_o === 1'b1) begin
				hi++;
				if (first == 0) first = per;
			end
		end while (chan_end_o !== 1'b1 && per < 1000);
	endtask

	// ==================================================================
	// tests
	initial begin
		reset_n_i   = 1'b0;
		reg_addr_i  = '0;
		reg_wdata_i = '0;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		repeat (6) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk_pin(pwm_pin_oe_o, 1'b0);
		rd(`TPP_OUTC_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(`TPP_STAT_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		wr(`TPP_MRLD_OFS, 32'h0000_0004);
		rd(`TPP_MRLD_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(8'h40, rv);
		chk_reg(rv, 32'h0000_0000);
		$display("test reset done");

		wr(`TPP_OUTC_OFS, UCE | TOE);
		wr(`TPP_MRLD_OFS, 32'hffff_0004);
		wr(`TPP_SRLD_OFS, 32'h0000_0002);
		wr(`TPP_PSC_OFS, 32'h0000_0000);
		rd(`TPP_MRLD_OFS, rv);
		chk_reg(rv, 32'h0000_0004);
		wr(`TPP_CTRL_OFS, START);
		rd(`TPP_CTRL_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(`TPP_STAT_OFS, rv);
		chk_reg(rv, 32'h0000_0003);
		chk_pin(pwm_pin_oe_o, 1'b1);
		for (int k = 0; k < 3; k++) begin
			wait_end();
			wr(`TPP_MRLD_OFS, 32'(tab_r[k]));
			wr(`TPP_SRLD_OFS, 32'(tab_s[k]));
			wr(`TPP_PSC_OFS, 32'(tab_p[k]));
			// let an end event take up the new reloads before timing a full period
			tick(40);
			measure();
			chk_cnt(per, (tab_r[k] + 1) * (tab_p[k] + 1));
			chk_cnt(hi, tab_s[k] * (tab_p[k] + 1));
			chk_cnt(first, tab_p[k] + 2);
		end
		rd(`TPP_MCNT_OFS, rv);
		rd(`TPP_MCNT_OFS, rv2);
		chk_reg(rv2, (rv >= 32'd2) ? rv - 32'd2 : rv + 32'd3);
		rd(`TPP_SCNT_OFS, rv);
		chk_pin(rv <= 32'd2, 1'b1);
		$display("test run done");

		wr(`TPP_CTRL_OFS, HALT);
		rd(`TPP_CTRL_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(`TPP_STAT_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(`TPP_MCNT_OFS, rv);
		pv = pwm_pin_o;
		tick(20);
		rd(`TPP_MCNT_OFS, rv2);
		chk_reg(rv2, rv);
		chk_pin(pwm_pin_o, pv);
		rd(`TPP_OUTC_OFS, rv);
		chk_pin(rv[`TPP_OUTC_TOUT], pv);
		$display("test halt done");

		// with the enable off hardware must not touch the output bit
		wr(`TPP_OUTC_OFS, UCE | TOUT);
		tick(3);
		chk_pin(pwm_pin_o, 1'b1);
		wr(`TPP_OUTC_OFS, UCE | TOE | TOUT);
		wr(`TPP_CTRL_OFS, START);
		wait_end();
		// enable cleared mid-pulse: hardware and software both want active
		wr(`TPP_OUTC_OFS, UCE | TOUT);
		tick(12);
		chk_pin(pwm_pin_o, 1'b1);
		wr(`TPP_OUTC_OFS, UCE);
		tick(3);
		chk_pin(pwm_pin_o, 1'b0);
		wr(`TPP_CTRL_OFS, HALT);
		$display("test output enable done");

		// active-low level, changed only while stopped
		wr(`TPP_OUTC_OFS, UCE | TOE | TOUT | LVL);
		wr(`TPP_CTRL_OFS, START);
		tick(40);
		measure();
		chk_cnt(per, tab_r[2] + 1);
		chk_cnt(hi, tab_r[2] + 1 - tab_s[2]);
		wr(`TPP_CTRL_OFS, HALT);
		$display("test active low done");

		wr(`TPP_OUTC_OFS, PHOLD | PLVL);
		tick(3);
		chk_pin(pwm_pin_oe_o, 1'b1);
		chk_pin(pwm_pin_o, 1'b1);
		rd(`TPP_OUTC_OFS, rv);
		chk_reg(rv, PHOLD | PLVL);
		rd(`TPP_MCNT_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		rd(`TPP_SRLD_OFS, rv);
		chk_reg(rv, 32'h0000_0000);
		wr(`TPP_OUTC_OFS, PHOLD);
		tick(3);
		chk_pin(pwm_pin_o, 1'b0);
		wr(`TPP_OUTC_OFS, 32'h0000_0000);
		tick(3);
		chk_pin(pwm_pin_oe_o, 1'b0);
		$display("test unit off done");
		conclude();
	end

endmodule
`default_nettype wire
